//--- include/flow_ctrl_pkg.sv
// Package for the program-flow and system-control execution block
package flow_ctrl_pkg;
	localparam int DATA_W = 8;
	localparam int PC_W = 11;
	localparam int RAM_AW = 7;
	localparam int IO_AW = 6;
	localparam logic [RAM_AW-1:0] BIT_RAM_LIMIT = 7'h3f;
	localparam logic [7:0] SP_STEP = 8'h02;
	localparam logic [PC_W-1:0] PC_RESET = 11'h000;
	localparam logic [7:0] SP_RESET = 8'h00;

	// Decoded operation codes presented by the fetch stage
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_CEQ_IMM = 5'h01,
		OP_CEQ_MEM = 5'h02,
		OP_CNE_IMM = 5'h03,
		OP_CNE_MEM = 5'h04,
		OP_TST_IO_LOW = 5'h05,
		OP_TST_IO_HIGH = 5'h06,
		OP_TST_MEM_LOW = 5'h07,
		OP_TST_MEM_HIGH = 5'h08,
		OP_INC_ACC_SKIP = 5'h09,
		OP_DEC_ACC_SKIP = 5'h0a,
		OP_INC_MEM_SKIP = 5'h0b,
		OP_DEC_MEM_SKIP = 5'h0c,
		OP_CALL = 5'h0d,
		OP_JUMP = 5'h0e,
		OP_RET = 5'h0f,
		OP_RET_IMM = 5'h10,
		OP_RETI = 5'h11,
		OP_PC_ADD = 5'h12,
		OP_INT_ENABLE = 5'h13,
		OP_INT_DISABLE = 5'h14,
		OP_HALT_ALL = 5'h15,
		OP_HALT_CORE = 5'h16,
		OP_SOFT_RESET = 5'h17,
		OP_WDOG_CLEAR = 5'h18,
		OP_INDEXED = 5'h19
	} op_e;

	typedef struct packed {
		op_e op;
		logic [DATA_W-1:0] imm;
		logic [RAM_AW-1:0] addr;
		logic [2:0] bit_sel;
		logic [PC_W-1:0] target;
	} instr_s;

	typedef struct packed {
		logic zero;
		logic carry;
		logic nibble_carry_flag;
		logic signed_wrap_flag;
	} flags_s;

	typedef enum logic [3:0] {
		ST_EXEC = 4'b0001,
		ST_SECOND = 4'b0010,
		ST_RET_READ = 4'b0100,
		ST_HALTED = 4'b1000
	} state_e;
endpackage

//--- rtl/skip_alu.sv
// Eight-bit add/subtract unit giving the four arithmetic flags
`timescale 1ns/1ps
module skip_alu (
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic subtract,
	output logic [7:0] result,
	output flow_ctrl_pkg::flags_s flags
);
	import flow_ctrl_pkg::*;
	logic [7:0] b_eff;
	logic [8:0] full;
	logic [4:0] low;
	always_comb begin
		b_eff = subtract ? ~b : b;
		full = {1'b0, a} + {1'b0, b_eff} + {8'h00, subtract};
		low = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, subtract};
		result = full[7:0];
		flags.zero = (full[7:0] == 8'h00);
		// Borrow is the inverted carry when subtracting
		flags.carry = subtract ? ~full[8] : full[8];
		flags.nibble_carry_flag = subtract ? ~low[4] : low[4];
		flags.signed_wrap_flag = (a[7] == b_eff[7]) && (full[7] != a[7]);
	end
endmodule

//--- rtl/branch_skip_system_control.sv
// Execution of compare/test/count-skip, call/return/jump and system-control operations
`timescale 1ns/1ps
module branch_skip_system_control #(
	parameter int PC_WIDTH = flow_ctrl_pkg::PC_W
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic instr_valid,
	input wire flow_ctrl_pkg::instr_s instr,
	input wire logic [7:0] ram_rdata,
	input wire logic [7:0] io_rdata,
	input wire logic [7:0] stack_rdata_lo,
	input wire logic [7:0] stack_rdata_hi,
	input wire logic wake,
	output logic instr_ready,
	output logic [PC_WIDTH-1:0] program_counter,
	output logic [7:0] stack_pointer,
	output logic [7:0] working_register,
	output flow_ctrl_pkg::flags_s flags,
	output logic global_int_enable,
	output logic [flow_ctrl_pkg::RAM_AW-1:0] ram_addr,
	output logic [7:0] ram_wdata,
	output logic ram_we,
	output logic [flow_ctrl_pkg::IO_AW-1:0] io_addr,
	output logic [7:0] stack_wdata_lo,
	output logic [7:0] stack_wdata_hi,
	output logic stack_we,
	output logic osc_stop,
	output logic core_clk_gate,
	output logic chip_reset_req,
	output logic wdog_clear,
	output logic bit_addr_fault
);
	import flow_ctrl_pkg::*;

	state_e state;
	logic skip_pending;
	logic [7:0] alu_a;
	logic [7:0] alu_b;
	logic alu_sub;
	logic [7:0] alu_res;
	flags_s alu_flags;
	logic sel_bit_ram;
	logic sel_bit_io;
	logic bit_ok;
	logic take_skip;
	logic exec_now;
	logic [PC_WIDTH-1:0] pc_next_seq;

	assign exec_now = instr_valid && (state == ST_EXEC) && !skip_pending;
	assign pc_next_seq = program_counter + {{(PC_WIDTH-1){1'b0}}, 1'b1};
	assign bit_ok = (instr.addr <= BIT_RAM_LIMIT);
	assign sel_bit_ram = ram_rdata[instr.bit_sel];
	assign sel_bit_io = io_rdata[instr.bit_sel];

	always_comb begin
		alu_a = working_register;
		alu_b = instr.imm;
		alu_sub = 1'b1;
		case (instr.op)
			OP_CEQ_MEM, OP_CNE_MEM: alu_b = ram_rdata;
			OP_INC_ACC_SKIP: begin
				alu_b = 8'h01;
				alu_sub = 1'b0;
			end
			OP_DEC_ACC_SKIP: alu_b = 8'h01;
			OP_INC_MEM_SKIP: begin
				alu_a = ram_rdata;
				alu_b = 8'h01;
				alu_sub = 1'b0;
			end
			OP_DEC_MEM_SKIP: begin
				alu_a = ram_rdata;
				alu_b = 8'h01;
			end
			default: ;
		endcase
	end

	skip_alu u_alu (
		.a(alu_a),
		.b(alu_b),
		.subtract(alu_sub),
		.result(alu_res),
		.flags(alu_flags)
	);

	always_comb begin
		case (instr.op)
			OP_CEQ_IMM, OP_CEQ_MEM: take_skip = alu_flags.zero;
			OP_CNE_IMM, OP_CNE_MEM: take_skip = !alu_flags.zero;
			OP_TST_IO_LOW: take_skip = !sel_bit_io;
			OP_TST_IO_HIGH: take_skip = sel_bit_io;
			OP_TST_MEM_LOW: take_skip = bit_ok && !sel_bit_ram;
			OP_TST_MEM_HIGH: take_skip = bit_ok && sel_bit_ram;
			OP_INC_ACC_SKIP, OP_DEC_ACC_SKIP: take_skip = alu_flags.zero;
			OP_INC_MEM_SKIP, OP_DEC_MEM_SKIP: take_skip = alu_flags.zero;
			default: take_skip = 1'b0;
		endcase
	end

	// Sequencing: second cycles, skip discards, halt
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state <= ST_EXEC;
			skip_pending <= 1'b0;
		end else begin
			case (state)
				ST_EXEC: begin
					if (skip_pending && instr_valid) begin
						skip_pending <= 1'b0;
					end else if (exec_now) begin
						case (instr.op)
							OP_JUMP, OP_CALL, OP_PC_ADD, OP_INDEXED: state <= ST_SECOND;
							OP_RET, OP_RET_IMM, OP_RETI: state <= ST_RET_READ;
							OP_HALT_ALL, OP_HALT_CORE: state <= ST_HALTED;
							default: skip_pending <= take_skip;
						endcase
					end
				end
				ST_SECOND, ST_RET_READ: state <= ST_EXEC;
				ST_HALTED: if (wake) state <= ST_EXEC;
				default: state <= ST_EXEC;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			instr_ready <= 1'b1;
		end else begin
			instr_ready <= !((exec_now && (instr.op inside {OP_JUMP, OP_CALL, OP_PC_ADD, OP_INDEXED,
				OP_RET, OP_RET_IMM, OP_RETI, OP_HALT_ALL, OP_HALT_CORE})) ||
				(state == ST_HALTED && !wake));
		end
	end

	// Program counter and stack pointer
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			program_counter <= PC_RESET[PC_WIDTH-1:0];
			stack_pointer <= SP_RESET;
		end else if (state == ST_RET_READ) begin
			program_counter <= PC_WIDTH'({stack_rdata_hi, stack_rdata_lo});
		end else if (skip_pending && instr_valid && state == ST_EXEC) begin
			program_counter <= pc_next_seq;
		end else if (exec_now) begin
			case (instr.op)
				OP_JUMP: program_counter <= PC_WIDTH'(instr.target);
				OP_CALL: begin
					program_counter <= PC_WIDTH'(instr.target);
					stack_pointer <= stack_pointer + SP_STEP;
				end
				OP_PC_ADD: program_counter <= program_counter + PC_WIDTH'(working_register);
				OP_RET, OP_RET_IMM, OP_RETI: stack_pointer <= stack_pointer - SP_STEP;
				OP_HALT_ALL, OP_HALT_CORE: program_counter <= pc_next_seq;
				default: program_counter <= pc_next_seq;
			endcase
		end
	end

	// Working register and flags
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			working_register <= 8'h00;
			flags <= '0;
		end else if (exec_now) begin
			case (instr.op)
				OP_CEQ_IMM, OP_CEQ_MEM, OP_CNE_IMM, OP_CNE_MEM: flags <= alu_flags;
				OP_INC_ACC_SKIP, OP_DEC_ACC_SKIP: begin
					working_register <= alu_res;
					flags <= alu_flags;
				end
				OP_INC_MEM_SKIP, OP_DEC_MEM_SKIP: flags <= alu_flags;
				OP_RET_IMM: working_register <= instr.imm;
				default: ;
			endcase
		end
	end

	// Global interrupt enable
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			global_int_enable <= 1'b0;
		end else if (exec_now) begin
			if (instr.op == OP_INT_ENABLE || instr.op == OP_RETI) global_int_enable <= 1'b1;
			else if (instr.op == OP_INT_DISABLE) global_int_enable <= 1'b0;
		end
	end

	// Memory, IO and stack strobes
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ram_addr <= '0;
			ram_wdata <= 8'h00;
			ram_we <= 1'b0;
			io_addr <= '0;
			stack_wdata_lo <= 8'h00;
			stack_wdata_hi <= 8'h00;
			stack_we <= 1'b0;
			bit_addr_fault <= 1'b0;
		end else begin
			ram_we <= exec_now && (instr.op inside {OP_INC_MEM_SKIP, OP_DEC_MEM_SKIP});
			ram_addr <= instr.addr;
			ram_wdata <= alu_res;
			io_addr <= instr.addr[IO_AW-1:0];
			stack_we <= exec_now && instr.op == OP_CALL;
			stack_wdata_lo <= 8'(pc_next_seq);
			stack_wdata_hi <= 8'(pc_next_seq >> 8);
			bit_addr_fault <= exec_now && (instr.op inside {OP_TST_MEM_LOW, OP_TST_MEM_HIGH}) && !bit_ok;
		end
	end

	// System control pulses and halt levels
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			osc_stop <= 1'b0;
			core_clk_gate <= 1'b0;
			chip_reset_req <= 1'b0;
			wdog_clear <= 1'b0;
		end else begin
			chip_reset_req <= exec_now && instr.op == OP_SOFT_RESET;
			wdog_clear <= exec_now && instr.op == OP_WDOG_CLEAR;
			// A halt issued in the same cycle as wake wins, so the levels agree with the halted state
			if (exec_now && instr.op == OP_HALT_ALL) begin
				osc_stop <= 1'b1;
				core_clk_gate <= 1'b1;
			end else if (exec_now && instr.op == OP_HALT_CORE) begin
				core_clk_gate <= 1'b1;
			end else if (wake) begin
				osc_stop <= 1'b0;
				core_clk_gate <= 1'b0;
			end
		end
	end

	a_ret_imm_load: assert property (@(posedge ref_clk) disable iff (srst)
		exec_now && instr.op == OP_RET_IMM |=> working_register == $past(instr.imm))
		else $error("return with value did not load working register");
	a_call_sp_step: assert property (@(posedge ref_clk) disable iff (srst)
		exec_now && instr.op == OP_CALL |=> stack_pointer == $past(stack_pointer) + 8'h02 && stack_we)
		else $error("call did not advance stack pointer by two");
	a_ret_sp_step: assert property (@(posedge ref_clk) disable iff (srst)
		exec_now && instr.op == OP_RET |=> stack_pointer == $past(stack_pointer) - 8'h02 ##1 state == ST_EXEC)
		else $error("return did not lower stack pointer by two");
	a_jump_two_cyc: assert property (@(posedge ref_clk) disable iff (srst)
		exec_now && instr.op == OP_JUMP |=> !instr_ready && program_counter == $past(instr.target) ##1 instr_ready)
		else $error("jump not two cycles");
	a_skip_discard: assert property (@(posedge ref_clk) disable iff (srst)
		exec_now && take_skip |=> skip_pending ##1 !ram_we && !stack_we)
		else $error("skipped instruction had side effects");
	a_cmp_keeps_acc: assert property (@(posedge ref_clk) disable iff (srst)
		exec_now && instr.op inside {OP_CEQ_IMM, OP_CNE_IMM} |=> $stable(working_register))
		else $error("compare changed working register");
	a_reti_enables: assert property (@(posedge ref_clk) disable iff (srst)
		exec_now && instr.op == OP_RETI |=> global_int_enable)
		else $error("interrupt return left interrupts disabled");
	a_disable_gie: assert property (@(posedge ref_clk) disable iff (srst)
		exec_now && instr.op == OP_INT_DISABLE |=> !global_int_enable)
		else $error("global disable ignored");
	a_wdog_flags: assert property (@(posedge ref_clk) disable iff (srst)
		exec_now && instr.op == OP_WDOG_CLEAR |=> wdog_clear && $stable(flags))
		else $error("watchdog restart wrong");
	a_halt_core_osc: assert property (@(posedge ref_clk) disable iff (srst)
		exec_now && instr.op == OP_HALT_CORE && !wake && !osc_stop |=> core_clk_gate && !osc_stop)
		else $error("core halt stopped oscillator");
endmodule

//--- sim/flow_mem_model.sv
// Behavioural stack memory, data RAM and IO space facing the flow-control block
`timescale 1ns/1ps
module flow_mem_model (
	input wire logic ref_clk,
	input wire flow_ctrl_pkg::instr_s instr,
	input wire logic [flow_ctrl_pkg::RAM_AW-1:0] ram_addr,
	input wire logic [7:0] ram_wdata,
	input wire logic ram_we,
	input wire logic [7:0] stack_pointer,
	input wire logic [7:0] stack_wdata_lo,
	input wire logic [7:0] stack_wdata_hi,
	input wire logic stack_we,
	output logic [7:0] ram_rdata,
	output logic [7:0] io_rdata,
	output logic [7:0] stack_rdata_lo,
	output logic [7:0] stack_rdata_hi
);
	import flow_ctrl_pkg::*;
	logic [7:0] ram [128];
	logic [7:0] io [64];
	logic [7:0] lo [256];
	logic [7:0] hi [256];
	// Reads are combinational: the core samples them in the cycle it executes
	assign ram_rdata = ram[instr.addr];
	assign io_rdata = io[instr.addr[5:0]];
	assign stack_rdata_lo = lo[stack_pointer];
	assign stack_rdata_hi = hi[stack_pointer];
	always @(posedge ref_clk) begin
		if (ram_we) begin
			ram[ram_addr] <= ram_wdata;
		end
		// The pointer has already stepped past the slot when the write pulse shows
		if (stack_we) begin
			lo[stack_pointer - 8'h02] <= stack_wdata_lo;
			hi[stack_pointer - 8'h02] <= stack_wdata_hi;
		end
	end
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the program-flow and system-control block
`timescale 1ns/1ps
module tb_top;
	import flow_ctrl_pkg::*;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic instr_valid = 1'b0;
	logic wake = 1'b0;
	instr_s instr = '0;
	logic [7:0] ram_rdata, io_rdata, stk_lo, stk_hi, stack_pointer, working_register, ram_wdata, wd_lo, wd_hi;
	logic [PC_W-1:0] program_counter;
	logic [RAM_AW-1:0] ram_addr;
	logic [IO_AW-1:0] io_addr;
	flags_s flags;
	logic instr_ready, global_int_enable, ram_we, stack_we, osc_stop, core_clk_gate, chip_reset_req, wdog_clear;
	logic bit_addr_fault;
	int fails = 0;
	int samples_checked = 0;
	op_e sk [12] = '{OP_CEQ_IMM, OP_CEQ_MEM, OP_CNE_IMM, OP_CNE_MEM, OP_TST_IO_LOW, OP_TST_IO_HIGH,
		OP_TST_MEM_LOW, OP_TST_MEM_HIGH, OP_INC_ACC_SKIP, OP_DEC_ACC_SKIP, OP_INC_MEM_SKIP, OP_DEC_MEM_SKIP};

	branch_skip_system_control dut (.ref_clk(ref_clk), .srst(srst), .instr_valid(instr_valid), .instr(instr),
		.ram_rdata(ram_rdata), .io_rdata(io_rdata), .stack_rdata_lo(stk_lo), .stack_rdata_hi(stk_hi), .wake(wake),
		.instr_ready(instr_ready), .program_counter(program_counter), .stack_pointer(stack_pointer),
		.working_register(working_register), .flags(flags), .global_int_enable(global_int_enable),
		.ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we), .io_addr(io_addr), .stack_wdata_lo(wd_lo),
		.stack_wdata_hi(wd_hi), .stack_we(stack_we), .osc_stop(osc_stop), .core_clk_gate(core_clk_gate),
		.chip_reset_req(chip_reset_req), .wdog_clear(wdog_clear), .bit_addr_fault(bit_addr_fault));
	flow_mem_model mem (.ref_clk(ref_clk), .instr(instr), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.ram_we(ram_we), .stack_pointer(stack_pointer), .stack_wdata_lo(wd_lo), .stack_wdata_hi(wd_hi),
		.stack_we(stack_we), .ram_rdata(ram_rdata), .io_rdata(io_rdata), .stack_rdata_lo(stk_lo),
		.stack_rdata_hi(stk_hi));

	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	function automatic flags_s sub_f(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] r;
		r = a - b;
		return '{r == 8'h00, a < b, a[3:0] < b[3:0], (a[7] != b[7]) && (r[7] != a[7])};
	endfunction

	function automatic flags_s add_f(input logic [7:0] a);
		logic [8:0] r;
		r = {1'b0, a} + 9'h001;
		return '{r[7:0] == 8'h00, r[8], a[3:0] == 4'hf, a == 8'h7f};
	endfunction

	task automatic tally_and_finish();
		if (fails == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		while (instr_ready !== 1'b1) begin
			n++;
			if (n > 20) begin
				fails++;
				tally_and_finish();
			end
			@(negedge ref_clk);
		end
	endtask

	// Valid stays high between calls so back-to-back issue never re-drives it in one step
	task automatic go(input op_e op, input logic [7:0] imm, input logic [6:0] ad, input logic [2:0] bs,
		input logic [10:0] tgt);
		wait_ready();
		instr = '{op, imm, ad, bs, tgt};
		instr_valid = 1'b1;
		@(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	task automatic set_acc(input logic [7:0] v, input logic [10:0] tgt);
		logic [10:0] back;
		logic [7:0] sp0;
		back = program_counter + 11'h001;
		sp0 = stack_pointer;
		go(OP_CALL, 8'h00, 7'h00, 3'h0, tgt);
		chk("call pc", {stack_pointer, program_counter}, {sp0 + SP_STEP, tgt});
		chk("call word", {instr_ready, stack_we, wd_hi[2:0], wd_lo}, {2'b01, back});
		go(OP_RET_IMM, v, 7'h00, 3'h0, 11'h000);
		chk("ret sp", {instr_ready, stack_pointer}, {1'b0, sp0});
		@(negedge ref_clk);
		chk("ret pc", {working_register, program_counter}, {v, back});
	endtask

	initial begin
		logic [7:0] a, b, ae, me;
		logic [6:0] ad;
		logic [2:0] bs;
		logic [10:0] pc0, j;
		logic skip;
		flags_s fe;
		op_e op;
		void'($urandom(9));
		for (int k = 0; k < 128; k++) begin
			mem.ram[k] = 8'($urandom);
		end
		repeat (3) @(negedge ref_clk);
		chk("reset", {instr_ready, global_int_enable, osc_stop, core_clk_gate, program_counter, stack_pointer,
			working_register, flags}, {4'b1000, PC_RESET, SP_RESET, 8'h00, 4'h0});
		srst = 1'b0;
		for (int i = 0; i < 40; i++) begin
			op = sk[$urandom_range(11)];
			// Even passes use the wrap corners 00, 01, fe and ff
			a = i[0] ? 8'($urandom) : {8{i[1]}} ^ {7'h00, i[2]};
			b = $urandom_range(1) ? a : 8'($urandom);
			ad = 7'($urandom_range(63));
			bs = 3'($urandom);
			j = 11'($urandom);
			set_acc(a, 11'($urandom));
			mem.ram[ad] = b;
			mem.io[ad[5:0]] = b;
			pc0 = program_counter;
			fe = flags;
			ae = a;
			me = b;
			case (op)
				OP_CEQ_IMM, OP_CEQ_MEM: begin skip = a == b; fe = sub_f(a, b); end
				OP_CNE_IMM, OP_CNE_MEM: begin skip = a != b; fe = sub_f(a, b); end
				OP_TST_IO_LOW, OP_TST_MEM_LOW: skip = !b[bs];
				OP_TST_IO_HIGH, OP_TST_MEM_HIGH: skip = b[bs];
				OP_INC_ACC_SKIP: begin ae = a + 8'h01; fe = add_f(a); end
				OP_DEC_ACC_SKIP: begin ae = a - 8'h01; fe = sub_f(a, 8'h01); end
				OP_INC_MEM_SKIP: begin me = b + 8'h01; fe = add_f(b); end
				default: begin me = b - 8'h01; fe = sub_f(b, 8'h01); end
			endcase
			if (op >= OP_INC_ACC_SKIP) skip = (op < OP_INC_MEM_SKIP) ? ae == 8'h00 : me == 8'h00;
			go(op, b, ad, bs, 11'h000);
			chk("flags", {working_register, flags}, {ae, fe});
			chk("io addr", io_addr, ad[5:0]);
			go(OP_JUMP, 8'h00, 7'h00, 3'h0, j);
			chk("skip pc", program_counter, skip ? pc0 + 11'h002 : j);
			go(OP_NOP, 8'h00, 7'h00, 3'h0, 11'h000);
			chk("mem", {mem.ram[ad], working_register, flags}, {me, ae, fe});
		end
		set_acc(8'h05, 11'h7ff);
		pc0 = program_counter;
		go(OP_PC_ADD, 8'h00, 7'h00, 3'h0, 11'h000);
		@(negedge ref_clk);
		chk("pcadd", program_counter, pc0 + 11'h005);
		mem.ram[7'h40] = 8'h00;
		go(OP_TST_MEM_LOW, 8'h00, 7'h40, 3'h0, 11'h000);
		chk("fault", bit_addr_fault, 1'b1);
		go(OP_JUMP, 8'h00, 7'h00, 3'h0, 11'h123);
		chk("fault skip", program_counter, 11'h123);
		go(OP_INT_ENABLE, 8'h00, 7'h00, 3'h0, 11'h000);
		chk("gie on", global_int_enable, 1'b1);
		go(OP_INT_DISABLE, 8'h00, 7'h00, 3'h0, 11'h000);
		chk("gie off", global_int_enable, 1'b0);
		// The call sits at 125h after two one-cycle steps from 123h, so it pushes 126h
		go(OP_CALL, 8'h00, 7'h00, 3'h0, 11'h400);
		go(OP_RETI, 8'h00, 7'h00, 3'h0, 11'h000);
		@(negedge ref_clk);
		chk("reti", {global_int_enable, program_counter}, {1'b1, 11'h126});
		fe = flags;
		go(OP_WDOG_CLEAR, 8'h00, 7'h00, 3'h0, 11'h000);
		chk("wdog", {wdog_clear, flags}, {1'b1, fe});
		go(OP_SOFT_RESET, 8'h00, 7'h00, 3'h0, 11'h000);
		chk("swreset", {wdog_clear, chip_reset_req}, 2'b01);
		go(OP_NOP, 8'h00, 7'h00, 3'h0, 11'h000);
		chk("swreset end", chip_reset_req, 1'b0);
		pc0 = program_counter;
		go(OP_INDEXED, 8'h00, 7'h00, 3'h0, 11'h000);
		chk("indexed", {instr_ready, program_counter}, {1'b0, pc0 + 11'h001});
		go(OP_CALL, 8'h00, 7'h00, 3'h0, 11'h2aa);
		go(OP_RET, 8'h00, 7'h00, 3'h0, 11'h000);
		chk("plain ret sp", {instr_ready, stack_pointer}, {1'b0, SP_RESET});
		@(negedge ref_clk);
		chk("plain ret pc", {program_counter, flags}, {pc0 + 11'h002, fe});
		for (int h = 0; h < 2; h++) begin
			go(h ? OP_HALT_CORE : OP_HALT_ALL, 8'h00, 7'h00, 3'h0, 11'h000);
			instr_valid = 1'b0;
			@(negedge ref_clk);
			chk("halt", {instr_ready, osc_stop, core_clk_gate}, h ? 3'b001 : 3'b011);
			wake = 1'b1;
			wait_ready();
			wake = 1'b0;
			chk("woken", {osc_stop, core_clk_gate}, 2'b00);
		end
		tally_and_finish();
	end
endmodule
